/* File: hw/pigng_defines.vh */
// Constants for the PCM input guard and noise gate: offsets, fields, resets and timing
`ifndef PIGNG_DEFINES_VH
`define PIGNG_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PIGNG_ADDR_GATE_THRESHOLD 16'h2030
`define PIGNG_ADDR_GATE_ENABLE 16'h2033
`define PIGNG_ADDR_CLOCK_WATCH 16'h2038
`define PIGNG_ADDR_DATA_WATCH 16'h2039
`define PIGNG_ADDR_CHECK_ENABLE 16'h203F

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PIGNG_RST_GATE_THRESHOLD 8'h32
`define PIGNG_RST_GATE_ENABLE 8'h00
`define PIGNG_RST_CLOCK_WATCH 8'h00
`define PIGNG_RST_DATA_WATCH 8'h00
`define PIGNG_RST_CHECK_ENABLE 8'h07

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PIGNG_GATE_ENTRY_LSB 0
`define PIGNG_GATE_EXIT_LSB 4
`define PIGNG_GATE_ON_BIT 0
`define PIGNG_SELF_RESUME_BIT 0
`define PIGNG_RATE_TOL_LSB 1
`define PIGNG_RATIO_TOL_LSB 4
`define PIGNG_WINDOW_LSB 0
`define PIGNG_FROZEN_LSB 2
`define PIGNG_LARGE_LSB 4
`define PIGNG_CLOCK_CHECK_BIT 0
`define PIGNG_FROZEN_CHECK_BIT 1
`define PIGNG_LARGE_CHECK_BIT 2
`define PIGNG_LEVEL_CODE_MAX 4'h9

// ----------------------------------------------------------------------------
// Link framing and timing
// ----------------------------------------------------------------------------
`define PIGNG_SAMPLE_W 16
`define PIGNG_BCLK_PER_FRAME 32
`define PIGNG_CLK_NS 10
`define PIGNG_FRAME_MIN_NS 15000
`define PIGNG_FRAME_MAX_NS 25000
`define PIGNG_FRAME_MIN_CYC (`PIGNG_FRAME_MIN_NS + `PIGNG_CLK_NS - 1) / `PIGNG_CLK_NS
`define PIGNG_FRAME_MAX_CYC `PIGNG_FRAME_MAX_NS / `PIGNG_CLK_NS
`define PIGNG_MS_NS 1000000
`define PIGNG_MS_CYC `PIGNG_MS_NS / `PIGNG_CLK_NS
`define PIGNG_WINDOW0_MS 64
`define PIGNG_WINDOW1_MS 256
`define PIGNG_WINDOW2_MS 1024
`define PIGNG_WINDOW3_MS 4096

`endif

/* File: hw/pigng_fault_filter.v */
// Consecutive bad/good frame filter that raises and clears one clock fault
`timescale 1ns/1ps

module pigng_fault_filter (
  input wire core_clk,
  input wire reset,
  input wire check_on,
  input wire frame_tick,
  input wire frame_bad,
  input wire [2:0] tolerance,
  output reg fault_r
);

  reg [6:0] run_r;
  wire [6:0] raise_count;
  wire [6:0] clear_count;

  // ----------------------------------------------------------------------------
  // Thresholds: n+1 bad frames to raise, 1 or 8(n+1) good frames to clear
  // ----------------------------------------------------------------------------
  assign raise_count = {4'h0, tolerance} + 7'h01;
  assign clear_count = (tolerance == 3'h0) ? 7'h01 : {raise_count[3:0], 3'h0};

  // Run counter restarts whenever a frame agrees with the present state
  always @(posedge core_clk) begin
    if (reset || !check_on) begin
      run_r <= 7'h00;
      fault_r <= 1'b0;
    end else if (frame_tick) begin
      if (frame_bad == fault_r) begin
        run_r <= 7'h00;
      end else if (run_r + 7'h01 >= (fault_r ? clear_count : raise_count)) begin
        run_r <= 7'h00;
        fault_r <= ~fault_r;
      end else begin
        run_r <= run_r + 7'h01;
      end
    end
  end

endmodule // pigng_fault_filter

/* File: hw/pigng_top.v */
// PCM input supervisor: noise gate, clock checks, data checks and register file
// Notes on behaviour
// - Noise gate works only while its enable bit is set; it resets cleared.
// - Enter idle when toggling low bits fall to entry level, code n means n+1.
// - Leave idle when toggling low bits reach exit level; exit level resets to 3.
// - Framing fault after n+1 bad-ratio frames; clears after 1 or 8(n+1) good.
// - Rate fault after n+1 bad-rate periods; clears after 1 or 8(n+1) good.
// - Any clock fault stops playback until clocks are valid and play restarts.
// - Self-resume bit set restarts playback on valid clocks; cleared stays stopped.
// - Data fault when magnitude stays above the large-sample level for the window.
// - Data fault when one value above the frozen level persists for the window.
// - Window field in bits 1:0 selects persistence time; resets to 0.
// - Window codes 0 to 3 are 64, 256, 1024 and 4096 ms.
// - Clock, large and frozen checks each run only when enabled; all reset on.
`timescale 1ns/1ps
`include "pigng_defines.vh"

module pigng_top #(
  parameter MS_CYCLES = `PIGNG_MS_CYC
) (
  input wire core_clk,
  input wire reset,
  input wire bit_clk_pin,
  input wire frame_clk_pin,
  input wire serial_data_pin,
  input wire play_request,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_r,
  output reg play_on_r,
  output reg gate_idle_r,
  output reg ratio_fault_out_r,
  output reg rate_fault_out_r,
  output reg data_fault_r
);

  localparam SW = `PIGNG_SAMPLE_W;
  // Check enables reset value, sized so its low bits can be selected
  localparam [7:0] CHECK_RST = `PIGNG_RST_CHECK_ENABLE;

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  reg [7:0] gate_threshold_ctl_r;
  reg [7:0] gate_enable_ctl_r;
  reg [7:0] clock_watch_ctl_r;
  reg [7:0] data_watch_ctl_r;
  reg [2:0] check_enable_r;

  wire gate_on = gate_enable_ctl_r[`PIGNG_GATE_ON_BIT];
  wire [3:0] gate_entry_level = gate_threshold_ctl_r[`PIGNG_GATE_ENTRY_LSB +: 4];
  wire [3:0] gate_exit_level = gate_threshold_ctl_r[`PIGNG_GATE_EXIT_LSB +: 4];
  wire clock_fault_self_resume = clock_watch_ctl_r[`PIGNG_SELF_RESUME_BIT];
  wire [2:0] rate_fault_tolerance = clock_watch_ctl_r[`PIGNG_RATE_TOL_LSB +: 3];
  wire [2:0] ratio_fault_tolerance = clock_watch_ctl_r[`PIGNG_RATIO_TOL_LSB +: 3];
  wire [1:0] sample_fault_window = data_watch_ctl_r[`PIGNG_WINDOW_LSB +: 2];
  wire [1:0] frozen_sample_level = data_watch_ctl_r[`PIGNG_FROZEN_LSB +: 2];
  wire [1:0] large_sample_level = data_watch_ctl_r[`PIGNG_LARGE_LSB +: 2];
  wire clock_check_on = check_enable_r[`PIGNG_CLOCK_CHECK_BIT];
  wire frozen_sample_check_on = check_enable_r[`PIGNG_FROZEN_CHECK_BIT];
  wire large_sample_check_on = check_enable_r[`PIGNG_LARGE_CHECK_BIT];

  // Writes store fields; unused bits of the narrow registers stay zero
  always @(posedge core_clk) begin
    if (reset) begin
      gate_threshold_ctl_r <= `PIGNG_RST_GATE_THRESHOLD;
      gate_enable_ctl_r <= `PIGNG_RST_GATE_ENABLE;
      clock_watch_ctl_r <= `PIGNG_RST_CLOCK_WATCH;
      data_watch_ctl_r <= `PIGNG_RST_DATA_WATCH;
      check_enable_r <= CHECK_RST[2:0];
    end else if (reg_write) begin
      case (reg_addr)
        `PIGNG_ADDR_GATE_THRESHOLD: gate_threshold_ctl_r <= reg_wdata;
        `PIGNG_ADDR_GATE_ENABLE: gate_enable_ctl_r <= {7'h00, reg_wdata[0]};
        `PIGNG_ADDR_CLOCK_WATCH: clock_watch_ctl_r <= {1'b0, reg_wdata[6:0]};
        `PIGNG_ADDR_DATA_WATCH: data_watch_ctl_r <= {2'h0, reg_wdata[5:0]};
        `PIGNG_ADDR_CHECK_ENABLE: check_enable_r <= reg_wdata[2:0];
        default: check_enable_r <= check_enable_r;
      endcase
    end
  end

  // Read data is registered one cycle after the read strobe; unmapped reads zero
  always @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `PIGNG_ADDR_GATE_THRESHOLD: reg_rdata_r <= gate_threshold_ctl_r;
        `PIGNG_ADDR_GATE_ENABLE: reg_rdata_r <= gate_enable_ctl_r;
        `PIGNG_ADDR_CLOCK_WATCH: reg_rdata_r <= clock_watch_ctl_r;
        `PIGNG_ADDR_DATA_WATCH: reg_rdata_r <= data_watch_ctl_r;
        `PIGNG_ADDR_CHECK_ENABLE: reg_rdata_r <= {5'h00, check_enable_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers and link edge detection
  // ----------------------------------------------------------------------------
  reg [2:0] meta_r;
  reg [2:0] sync_r;
  reg bclk_d_r;
  reg lrclk_d_r;

  // Two flops per pin; only the second stage feeds logic
  always @(posedge core_clk) begin
    if (reset) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      bclk_d_r <= 1'b0;
      lrclk_d_r <= 1'b0;
    end else begin
      meta_r <= {serial_data_pin, frame_clk_pin, bit_clk_pin};
      sync_r <= meta_r;
      bclk_d_r <= sync_r[0];
      lrclk_d_r <= sync_r[1];
    end
  end

  wire bclk_rise = sync_r[0] && !bclk_d_r;
  wire frame_start = sync_r[1] && !lrclk_d_r;

  // ----------------------------------------------------------------------------
  // Serial capture: the last SW bits before a frame start form the sample
  // ----------------------------------------------------------------------------
  reg [SW-1:0] shift_r;
  reg [SW-1:0] sample_r;
  reg [SW-1:0] prev_sample_r;
  reg sample_tick_r;
  reg [7:0] bclk_count_r;
  reg [11:0] frame_cyc_r;
  reg ratio_bad_r;
  reg rate_bad_r;
  reg first_frame_r;

  // Counts bit clocks and core cycles per frame, then latches the sample
  always @(posedge core_clk) begin
    if (reset) begin
      shift_r <= {SW{1'b0}};
      sample_r <= {SW{1'b0}};
      prev_sample_r <= {SW{1'b0}};
      sample_tick_r <= 1'b0;
      bclk_count_r <= 8'h00;
      frame_cyc_r <= 12'h000;
      ratio_bad_r <= 1'b0;
      rate_bad_r <= 1'b0;
      first_frame_r <= 1'b1;
    end else begin
      sample_tick_r <= frame_start && !first_frame_r;
      if (bclk_rise) begin
        shift_r <= {shift_r[SW-2:0], sync_r[2]};
      end
      if (frame_start) begin
        first_frame_r <= 1'b0;
        prev_sample_r <= sample_r;
        sample_r <= shift_r;
        ratio_bad_r <= (bclk_count_r + (bclk_rise ? 8'h01 : 8'h00)) != `PIGNG_BCLK_PER_FRAME;
        rate_bad_r <= (frame_cyc_r < `PIGNG_FRAME_MIN_CYC) ||
                      (frame_cyc_r > `PIGNG_FRAME_MAX_CYC);
        bclk_count_r <= 8'h00;
        frame_cyc_r <= 12'h000;
      end else begin
        if (bclk_rise && bclk_count_r != 8'hFF) begin
          bclk_count_r <= bclk_count_r + 8'h01;
        end
        if (frame_cyc_r != 12'hFFF) begin
          frame_cyc_r <= frame_cyc_r + 12'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Clock checks and playback control
  // ----------------------------------------------------------------------------
  wire ratio_fault;
  wire rate_fault;

  // Framing check on bit clocks per frame
  pigng_fault_filter u_ratio_filter (
    .core_clk(core_clk),
    .reset(reset),
    .check_on(clock_check_on),
    .frame_tick(sample_tick_r),
    .frame_bad(ratio_bad_r),
    .tolerance(ratio_fault_tolerance),
    .fault_r(ratio_fault)
  );

  // Frame rate check on core cycles per frame
  pigng_fault_filter u_rate_filter (
    .core_clk(core_clk),
    .reset(reset),
    .check_on(clock_check_on),
    .frame_tick(sample_tick_r),
    .frame_bad(rate_bad_r),
    .tolerance(rate_fault_tolerance),
    .fault_r(rate_fault)
  );

  reg stopped_r;
  wire clock_fault = ratio_fault || rate_fault;

  // A fault latches a stop; it lifts on valid clocks if self-resume is set,
  // otherwise only when the playback request is withdrawn and made again
  always @(posedge core_clk) begin
    if (reset) begin
      stopped_r <= 1'b0;
      play_on_r <= 1'b0;
      ratio_fault_out_r <= 1'b0;
      rate_fault_out_r <= 1'b0;
    end else begin
      ratio_fault_out_r <= ratio_fault;
      rate_fault_out_r <= rate_fault;
      if (clock_fault) begin
        stopped_r <= 1'b1;
      end else if (clock_fault_self_resume || !play_request) begin
        stopped_r <= 1'b0;
      end
      play_on_r <= play_request && !clock_fault && !stopped_r;
    end
  end

  // ----------------------------------------------------------------------------
  // Noise gate
  // ----------------------------------------------------------------------------

  // Width of the span from bit 0 up to the highest changed bit, saturating at 15
  function [3:0] pigng_span;
    input [SW-1:0] diff;
    integer i;
    begin
      pigng_span = 4'h0;
      for (i = 0; i < SW; i = i + 1) begin
        if (diff[i]) begin
          pigng_span = (i >= 14) ? 4'hF : i[3:0] + 4'h1;
        end
      end
    end
  endfunction

  // Reserved codes act as the largest legal code
  function [3:0] pigng_level;
    input [3:0] code;
    begin
      pigng_level = ((code > `PIGNG_LEVEL_CODE_MAX) ? `PIGNG_LEVEL_CODE_MAX : code) + 4'h1;
    end
  endfunction

  reg [3:0] toggle_span_r;
  reg span_valid_r;

  // Measure per frame; disabling the gate clears measurement and idle state
  always @(posedge core_clk) begin
    if (reset || !gate_on) begin
      toggle_span_r <= 4'h0;
      span_valid_r <= 1'b0;
      gate_idle_r <= 1'b0;
    end else begin
      span_valid_r <= sample_tick_r;
      if (sample_tick_r) begin
        toggle_span_r <= pigng_span(sample_r ^ prev_sample_r);
      end
      if (span_valid_r) begin
        if (!gate_idle_r && toggle_span_r <= pigng_level(gate_entry_level)) begin
          gate_idle_r <= 1'b1;
        end else if (gate_idle_r && toggle_span_r >= pigng_level(gate_exit_level)) begin
          gate_idle_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Data checks
  // ----------------------------------------------------------------------------
  wire [SW-1:0] magnitude = sample_r[SW-1] ? (~sample_r + 16'h0001) : sample_r;
  wire [SW-1:0] large_limit = 16'h0400 << large_sample_level;
  wire [SW-1:0] frozen_limit = 16'h0001 << {frozen_sample_level, 1'b0};
  wire large_now = large_sample_check_on && (magnitude >= large_limit);
  wire frozen_now = frozen_sample_check_on && (sample_r == prev_sample_r) &&
                    (magnitude >= frozen_limit);
  reg bad_data_r;
  reg [16:0] ms_div_r;
  reg [12:0] bad_ms_r;
  reg [12:0] window_ms;
  // Window lengths at the width of the millisecond counter
  localparam [12:0] WINDOW0_MS = `PIGNG_WINDOW0_MS;
  localparam [12:0] WINDOW1_MS = `PIGNG_WINDOW1_MS;
  localparam [12:0] WINDOW2_MS = `PIGNG_WINDOW2_MS;
  localparam [12:0] WINDOW3_MS = `PIGNG_WINDOW3_MS;

  // Window code to milliseconds
  always @* begin
    case (sample_fault_window)
      2'h0: window_ms = WINDOW0_MS;
      2'h1: window_ms = WINDOW1_MS;
      2'h2: window_ms = WINDOW2_MS;
      default: window_ms = WINDOW3_MS;
    endcase
  end

  // Condition re-evaluated each frame; bad time counted in ms ticks
  always @(posedge core_clk) begin
    if (reset) begin
      bad_data_r <= 1'b0;
      ms_div_r <= 17'h00000;
      bad_ms_r <= 13'h0000;
      data_fault_r <= 1'b0;
    end else begin
      if (sample_tick_r) begin
        bad_data_r <= large_now || frozen_now;
      end
      if (!bad_data_r || !(large_sample_check_on || frozen_sample_check_on)) begin
        ms_div_r <= 17'h00000;
        bad_ms_r <= 13'h0000;
        data_fault_r <= 1'b0;
      end else if (ms_div_r == MS_CYCLES[16:0] - 17'h00001) begin
        ms_div_r <= 17'h00000;
        if (bad_ms_r + 13'h0001 >= window_ms) begin
          data_fault_r <= 1'b1;
        end else begin
          bad_ms_r <= bad_ms_r + 13'h0001;
        end
      end else begin
        ms_div_r <= ms_div_r + 17'h00001;
      end
    end
  end

endmodule // pigng_top

/* File: verif/pigng_host_model.sv */
// PCM host model that drives bit clock, frame clock and serial data
`timescale 1ns/1ps

module pigng_host_model (
  output reg bit_clk_pin,
  output reg frame_clk_pin,
  output reg serial_data_pin
);
  // Bit clock stands low outside frames
  initial begin
    bit_clk_pin = 1'b0;
    frame_clk_pin = 1'b0;
    serial_data_pin = 1'b0;
  end

  // One frame of nb bit clocks, sample MSB first in the last 16 slots, then the next rise
  task frame(input [15:0] smp, input integer nb, input integer per_ns);
    integer i;
    begin
      for (i = 0; i < nb; i = i + 1) begin
        serial_data_pin = (nb - 1 - i < 16) ? smp[nb - 1 - i] : 1'b0;
        #40 bit_clk_pin = 1'b1;
        #40 bit_clk_pin = 1'b0;
        if (i == 15) frame_clk_pin = 1'b0;
      end
      serial_data_pin = ~serial_data_pin; // Released line shows the inverse
      #(per_ns - 80 * nb) frame_clk_pin = 1'b1;
    end
  endtask
endmodule // pigng_host_model

/* File: verif/pigng_checker.sv */
// Port checker for the PCM input guard and noise gate
`timescale 1ns/1ps

module pigng_checker (
  input wire core_clk,
  input wire reset,
  input wire frame_clk_pin,
  input wire play_request,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_r,
  input wire play_on_r,
  input wire gate_idle_r,
  input wire ratio_fault_out_r,
  input wire rate_fault_out_r,
  input wire data_fault_r
);
  reg gate_on_r;
  reg resume_r;
  reg [2:0] check_on_r;
  reg [3:0] since_frame_r;
  reg frame_d_r;
  wire any_fault = ratio_fault_out_r | rate_fault_out_r;

  // Shadow of control bits and cycles since the last frame clock rise
  always @(posedge core_clk) begin
    frame_d_r <= frame_clk_pin;
    if (reset) begin
      gate_on_r <= 1'b0;
      resume_r <= 1'b0;
      check_on_r <= 3'h7;
      since_frame_r <= 4'hF;
    end else begin
      if (reg_write && reg_addr == 16'h2033) gate_on_r <= reg_wdata[0];
      if (reg_write && reg_addr == 16'h2038) resume_r <= reg_wdata[0];
      if (reg_write && reg_addr == 16'h203F) check_on_r <= reg_wdata[2:0];
      if (frame_clk_pin && !frame_d_r) since_frame_r <= 4'h0;
      else if (since_frame_r != 4'hF) since_frame_r <= since_frame_r + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_fault_on; $rose(any_fault); endsequence
  sequence s_fault_off; $fell(any_fault); endsequence

  property p_reset_quiet;
    disable iff (1'b0) reset |=> !play_on_r && !gate_idle_r && !data_fault_r && !any_fault;
  endproperty
  property p_stop; s_fault_on |-> ##[0:3] !play_on_r; endproperty
  property p_resume; s_fault_off ##0 (resume_r && play_request) |-> ##[0:4] play_on_r; endproperty
  property p_hold; s_fault_off ##0 !resume_r |-> !play_on_r [*3]; endproperty
  property p_ratio_frame; $changed(ratio_fault_out_r) |-> since_frame_r <= 4'h8; endproperty
  property p_rate_frame; $changed(rate_fault_out_r) |-> since_frame_r <= 4'h8; endproperty
  property p_clock_off; !check_on_r[0] && !$past(check_on_r[0], 4) |-> !any_fault; endproperty
  property p_data_off;
    check_on_r[2:1] == 2'h0 && $past(check_on_r[2:1], 4) == 2'h0 |-> !data_fault_r;
  endproperty
  property p_gate_off; !gate_on_r && !$past(gate_on_r, 4) |-> !gate_idle_r; endproperty
  property p_gate_read;
    reg_read && reg_addr == 16'h2033 |=> reg_rdata_r == {7'h00, gate_on_r};
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_stop: assert property (p_stop) else $error("playback kept on a clock fault");
  a_resume: assert property (p_resume) else $error("playback did not resume");
  a_hold: assert property (p_hold) else $error("playback resumed by itself");
  a_ratio_frame: assert property (p_ratio_frame) else $error("framing fault off frame");
  a_rate_frame: assert property (p_rate_frame) else $error("rate fault off frame");
  a_clock_off: assert property (p_clock_off) else $error("clock fault while off");
  a_data_off: assert property (p_data_off) else $error("data fault while off");
  a_gate_off: assert property (p_gate_off) else $error("gate idle while off");
  a_gate_read: assert property (p_gate_read) else $error("gate enable readback wrong");
endmodule // pigng_checker

bind pigng_top pigng_checker pigng_checker_i (.core_clk, .reset, .frame_clk_pin, .play_request,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata_r, .play_on_r, .gate_idle_r,
  .ratio_fault_out_r, .rate_fault_out_r, .data_fault_r);

/* File: verif/pigng_top_bench.sv */
// Self-checking bench for the PCM input guard and noise gate
`timescale 1ns/1ps

module pigng_top_bench;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg play_request = 1'b1;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  wire bit_clk_pin, frame_clk_pin, serial_data_pin;
  wire [7:0] reg_rdata_r;
  wire play_on_r, gate_idle_r, ratio_fault_out_r, rate_fault_out_r, data_fault_r;
  integer n_fail = 0;
  integer comparisons = 0;
  integer k;

  // Core clock at 100 MHz
  always #5 core_clk = ~core_clk;

  pigng_host_model pigng_host_model_i (.bit_clk_pin(bit_clk_pin),
    .frame_clk_pin(frame_clk_pin), .serial_data_pin(serial_data_pin));
  pigng_top #(.MS_CYCLES(10)) pigng_top_i (.core_clk(core_clk), .reset(reset),
    .bit_clk_pin(bit_clk_pin), .frame_clk_pin(frame_clk_pin),
    .serial_data_pin(serial_data_pin), .play_request(play_request), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_r(reg_rdata_r), .play_on_r(play_on_r), .gate_idle_r(gate_idle_r),
    .ratio_fault_out_r(ratio_fault_out_r), .rate_fault_out_r(rate_fault_out_r),
    .data_fault_r(data_fault_r));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] exp);
    begin
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      @(posedge core_clk);
      #1 chk("rdata", reg_rdata_r, exp);
    end
  endtask
  // Sends n like frames, letting each frame check settle
  task fr(input [15:0] smp, input integer nb, input integer per, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        pigng_host_model_i.frame(smp, nb, per);
        repeat (10) @(posedge core_clk);
      end
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  // Register reset values, readback and an unmapped address
  task t_regs;
    begin
      rd(16'h2030, 8'h32);
      rd(16'h2033, 8'h00);
      rd(16'h2038, 8'h00);
      rd(16'h2039, 8'h00);
      rd(16'h203F, 8'h07);
      rd(16'h2031, 8'h00);
      wr(16'h2030, 8'h95);
      rd(16'h2030, 8'h95);
      wr(16'h2030, 8'h32);
    end
  endtask
  // Good frames after reset leave playback on
  task t_start;
    begin
      fr(16'h0000, 32, 16000, 2);
      chk("play", play_on_r, 8'h01);
    end
  endtask
  // Rate fault after two short periods, clear after 16 good ones, self-resume
  task t_rate;
    begin
      wr(16'h2038, 8'h03);
      fr(16'h0000, 32, 5000, 1);
      chk("rate", rate_fault_out_r, 8'h00);
      fr(16'h0000, 32, 5000, 1);
      chk("rate", rate_fault_out_r, 8'h01);
      chk("play", play_on_r, 8'h00);
      fr(16'h0000, 32, 16000, 15);
      chk("rate", rate_fault_out_r, 8'h01);
      fr(16'h0000, 32, 16000, 1);
      chk("rate", rate_fault_out_r, 8'h00);
      chk("play", play_on_r, 8'h01);
    end
  endtask
  // Framing fault on one short frame, manual restart only
  task t_ratio;
    begin
      wr(16'h2038, 8'h00);
      fr(16'h0000, 30, 16000, 1);
      chk("ratio", ratio_fault_out_r, 8'h01);
      chk("play", play_on_r, 8'h00);
      fr(16'h0000, 32, 16000, 1);
      chk("ratio", ratio_fault_out_r, 8'h00);
      chk("play", play_on_r, 8'h00);
      @(posedge core_clk);
      play_request <= 1'b0;
      repeat (5) @(posedge core_clk);
      play_request <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1 chk("play", play_on_r, 8'h01);
    end
  endtask
  // Large and frozen samples, checks switched off, shortest and longest windows
  task t_data;
    begin
      wr(16'h203F, 8'h05);
      fr(16'h2000, 32, 16000, 3);
      chk("data", data_fault_r, 8'h01);
      wr(16'h203F, 8'h01);
      repeat (2) @(posedge core_clk);
      #1 chk("data", data_fault_r, 8'h00);
      wr(16'h203F, 8'h03);
      wr(16'h2039, 8'h0C);
      fr(16'h0100, 32, 16000, 3);
      chk("data", data_fault_r, 8'h01);
      wr(16'h2039, 8'h0F);
      fr(16'h0000, 32, 16000, 1);
      chk("data", data_fault_r, 8'h00);
      fr(16'h0100, 32, 16000, 3);
      chk("data", data_fault_r, 8'h00);
    end
  endtask
  // Gate enters idle on one toggling bit, leaves on six, stays off when disabled
  task t_gate;
    begin
      wr(16'h2033, 8'h01);
      for (k = 0; k < 4; k = k + 1) fr(16'h0010 | k[0], 32, 16000, 1);
      chk("idle", gate_idle_r, 8'h01);
      for (k = 0; k < 4; k = k + 1) fr(k[0] ? 16'h0030 : 16'h0010, 32, 16000, 1);
      chk("idle", gate_idle_r, 8'h00);
      wr(16'h2033, 8'h00);
      for (k = 0; k < 3; k = k + 1) fr(16'h0010 | k[0], 32, 16000, 1);
      chk("idle", gate_idle_r, 8'h00);
    end
  endtask
  // All checks off: short periods at tolerance 0 raise nothing, playback stays on
  task t_off;
    begin
      wr(16'h203F, 8'h00);
      fr(16'h0000, 32, 5000, 2);
      chk("rate", rate_fault_out_r, 8'h00);
      chk("play", play_on_r, 8'h01);
      chk("data", data_fault_r, 8'h00);
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_regs;
    t_start;
    t_rate;
    t_ratio;
    t_data;
    t_gate;
    t_off;
    test_done;
  end

  // Watchdog: about 1.3 times the expected run of some 70,000 cycles
  initial begin
    #900000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // pigng_top_bench
